/* File: verilog/status_word_cfg.svh */
// constants for the status word and bank select block
`ifndef STATUS_WORD_CFG_SVH
`define STATUS_WORD_CFG_SVH
`define SW_ADDR_LO        12'hfb0
`define SW_ADDR_HI        12'hfb1
`define SW_BIT_MBE        7
`define SW_BIT_RBE        6
`define SW_BIT_IST_HI     5
`define SW_BIT_IST_LO     4
`define SW_BIT_CARRY      3
`define SW_BIT_SK2        2
`define SW_BIT_SK1        1
`define SW_BIT_SK0        0
`define VEC_BIT_MBE       7
`define VEC_BIT_RBE       6
`define FIXED_BANK        4'h0
`define MBS_RESET         4'h0
`define RBS_RESET         4'h0
`define IST_LEVEL0        2'h0
`define IST_LEVEL1        2'h1
`define IST_LEVEL2        2'h2
`define MEM_BANK_TOP      4'hf
`endif

/* File: verilog/status_word_pkg.sv */
// types for the status word and bank select block
package status_word_pkg;
  typedef enum logic [3:0] {
    op_none,
    op_carry_set,
    op_carry_clr,
    op_carry_not,
    op_carry_skip,
    op_carry_arith,
    op_bit_load,
    op_bit_store,
    op_bit_and,
    op_bit_or,
    op_bit_xor
  } carry_op_e;
  typedef enum logic [2:0] {
    ev_none,
    ev_call,
    ev_ret,
    ev_irq,
    ev_return_from_interrupt,
    ev_reset_vec
  } flow_event_e;
endpackage

/* File: verilog/status_word_and_bank_select.sv */
// status word, carry bit accumulator and bank select registers
`timescale 1ns/1ns
`include "status_word_cfg.svh"
module status_word_and_bank_select (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       reset_n,
  // vector byte for reset and vectored interrupts
  input  wire logic [7:0]                 vector_byte,
  // carry operations
  input  wire status_word_pkg::carry_op_e carry_op,
  input  wire logic                       arith_carry,
  input  wire logic                       mem_bit_in,
  // skip flags from the sequencer
  input  wire logic                       skip_load,
  input  wire logic [2:0]                 skip_in,
  // control flow events and stack data
  input  wire status_word_pkg::flow_event_e flow_event,
  input  wire logic [7:0]                 stack_in,
  // data memory writes to the status word
  input  wire logic                       mem_wr,
  input  wire logic [11:0]                mem_addr,
  input  wire logic [3:0]                 mem_wdata,
  // bank select instructions
  input  wire logic                       sel_mem_bank,
  input  wire logic                       sel_reg_bank,
  input  wire logic [3:0]                 bank_arg,
  input  wire logic                       pop_bank_select,
  // outputs
  output logic [7:0]                      status_word,
  output logic [7:0]                      status_push,
  output logic [7:0]                      bank_select,
  output logic                            carry_flag,
  output logic                            carry_skip,
  output logic                            mem_bit_out,
  output logic [3:0]                      data_bank,
  output logic [1:0]                      reg_bank,
  output logic                            irq_any_ok,
  output logic                            irq_higher_ok,
  output logic                            level_illegal
);
  import status_word_pkg::*;

  logic       rst_meta_reg;
  logic       rst_sync_reg;
  logic       init_pend_reg;
  logic       carry_reg;
  logic [2:0] skip_reg;
  logic [1:0] level_reg;
  logic       mbe_reg;
  logic       rbe_reg;
  logic [3:0] mbs_reg;
  logic [3:0] rbs_reg;
  logic [1:0] level_next;
  logic [7:0] word_next;

  function automatic logic bank_ok(input logic [3:0] b);
    bank_ok = (b[3:2] == 2'h0) || (b == `MEM_BANK_TOP);
  endfunction

  function automatic logic [7:0] pack_word(input logic mem_bank_expand_en,
                                           input logic reg_bank_expand_en,
                                           input logic [1:0] lvl,
                                           input logic cy,
                                           input logic [2:0] sk);
    logic [7:0] w;
    w = 8'h00;
    w[`SW_BIT_MBE] = mem_bank_expand_en;
    w[`SW_BIT_RBE] = reg_bank_expand_en;
    w[`SW_BIT_IST_HI] = lvl[1];
    w[`SW_BIT_IST_LO] = lvl[0];
    w[`SW_BIT_CARRY] = cy;
    w[`SW_BIT_SK2] = sk[2];
    w[`SW_BIT_SK1] = sk[1];
    w[`SW_BIT_SK0] = sk[0];
    pack_word = w;
  endfunction

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // vector byte is sampled on the first clock after release
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg)
      init_pend_reg <= 1'b1;
    else
      init_pend_reg <= 1'b0;
  end

  // carry: no reset, software must initialise it
  always_ff @(posedge ref_clk) begin
    if (flow_event == ev_irq || flow_event == ev_return_from_interrupt) begin
      if (flow_event == ev_return_from_interrupt)
        carry_reg <= stack_in[`SW_BIT_CARRY];
    end else begin
      case (carry_op)
        op_carry_set:   carry_reg <= 1'b1;
        op_carry_clr:   carry_reg <= 1'b0;
        op_carry_not:   carry_reg <= ~carry_reg;
        op_carry_arith: carry_reg <= arith_carry;
        op_bit_load:    carry_reg <= mem_bit_in;
        op_bit_and:     carry_reg <= carry_reg & mem_bit_in;
        op_bit_or:      carry_reg <= carry_reg | mem_bit_in;
        op_bit_xor:     carry_reg <= carry_reg ^ mem_bit_in;
        default:        carry_reg <= carry_reg;
      endcase
    end
  end

  // skip bits come from skip_in or the stack on return from interrupt, never from memory writes
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg)
      skip_reg <= 3'h0;
    else if (flow_event == ev_return_from_interrupt)
      skip_reg <= stack_in[`SW_BIT_SK2:`SW_BIT_SK0];
    else if (skip_load)
      skip_reg <= skip_in;
  end

  always_comb begin
    level_next = level_reg;
    if (level_reg != `IST_LEVEL2)
      level_next = level_reg + 2'h1;
  end

  // level field: the only part of fb0 reachable by memory writes
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg)
      level_reg <= `IST_LEVEL0;
    else if (flow_event == ev_irq)
      level_reg <= level_next;
    else if (flow_event == ev_return_from_interrupt)
      level_reg <= stack_in[`SW_BIT_IST_HI:`SW_BIT_IST_LO];
    else if (mem_wr && mem_addr == `SW_ADDR_LO)
      level_reg <= mem_wdata[1:0];
  end

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      mbe_reg <= 1'b0;
      rbe_reg <= 1'b0;
    end else if (init_pend_reg || flow_event == ev_reset_vec ||
                 flow_event == ev_irq) begin
      mbe_reg <= vector_byte[`VEC_BIT_MBE];
      rbe_reg <= vector_byte[`VEC_BIT_RBE];
    end else if (flow_event == ev_ret || flow_event == ev_return_from_interrupt) begin
      mbe_reg <= stack_in[`SW_BIT_MBE];
      rbe_reg <= stack_in[`SW_BIT_RBE];
    end
  end

  // fb1 ignores memory writes entirely
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg)
      mbs_reg <= `MBS_RESET;
    else if (pop_bank_select)
      mbs_reg <= stack_in[7:4];
    else if (sel_mem_bank && bank_ok(bank_arg))
      mbs_reg <= bank_arg;
  end

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg)
      rbs_reg <= `RBS_RESET;
    else if (pop_bank_select)
      rbs_reg <= stack_in[3:0];
    else if (sel_reg_bank && bank_arg[3:2] == 2'h0)
      rbs_reg <= bank_arg;
  end

  always_comb begin
    word_next = pack_word(mbe_reg, rbe_reg, level_reg, carry_reg, skip_reg);
  end

  // registered outputs, one cycle behind state
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      status_word   <= 8'h00;
      status_push   <= 8'h00;
      bank_select   <= 8'h00;
      carry_flag    <= 1'b0;
      carry_skip    <= 1'b0;
      mem_bit_out   <= 1'b0;
      data_bank     <= `FIXED_BANK;
      reg_bank      <= 2'h0;
      irq_any_ok    <= 1'b1;
      irq_higher_ok <= 1'b1;
      level_illegal <= 1'b0;
    end else begin
      status_word <= word_next;
      if (flow_event == ev_irq)
        status_push <= word_next;
      else
        status_push <= {mbe_reg, rbe_reg, 6'h00};
      bank_select <= {mbs_reg, rbs_reg};
      carry_flag  <= carry_reg;
      carry_skip  <= (carry_op == op_carry_skip) && carry_reg;
      mem_bit_out <= carry_reg;
      data_bank   <= mbe_reg ? mbs_reg : `FIXED_BANK;
      reg_bank    <= rbe_reg ? rbs_reg[1:0] : 2'h0;
      irq_any_ok    <= (level_reg == `IST_LEVEL0);
      irq_higher_ok <= (level_reg == `IST_LEVEL0) ||
                       (level_reg == `IST_LEVEL1);
      level_illegal <= (level_reg == 2'h3);
    end
  end
endmodule // status_word_and_bank_select

/* File: bench/status_word_asserts.sv */
// port assertions for the status word and bank select block
`timescale 1ns/1ns
module status_word_asserts
  import status_word_pkg::*;
(
  input wire logic        ref_clk, reset_n, sel_mem_bank, sel_reg_bank,
  input wire logic        pop_bank_select, carry_flag, mem_bit_out,
  input wire logic        irq_any_ok, irq_higher_ok, level_illegal,
  input wire logic [3:0]  bank_arg, data_bank,
  input wire logic [1:0]  reg_bank,
  input wire logic [7:0]  stack_in, status_word, status_push, bank_select,
  input wire flow_event_e flow_event,
  input wire carry_op_e   carry_op
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire ok_arg = bank_arg < 4'h4 || bank_arg == 4'hf;
  a_mbank_load: assert property (
    sel_mem_bank && ok_arg && !pop_bank_select
    |=> ##1 bank_select[7:4] == $past(bank_arg, 2)) else $error("mbs load");
  a_mbank_refuse: assert property (
    (sel_mem_bank && !ok_arg && !pop_bank_select) ##1
    !(sel_mem_bank || pop_bank_select) |=> $stable(bank_select[7:4]))
    else $error("mbs refuse");
  a_rbank_load: assert property (
    sel_reg_bank && bank_arg < 4'h4 && !pop_bank_select
    |=> ##1 bank_select[3:0] == $past(bank_arg, 2)) else $error("rbs load");
  a_bank_pop: assert property (
    pop_bank_select |=> ##1 bank_select == $past(stack_in, 2))
    else $error("bank pop");
  a_bank_map: assert property (
    data_bank == (status_word[7] ? bank_select[7:4] : 4'h0) &&
    reg_bank == (status_word[6] ? bank_select[1:0] : 2'h0))
    else $error("bank map");
  a_level_decode: assert property (
    irq_any_ok == (status_word[5:4] == 2'h0) &&
    irq_higher_ok == !status_word[5] && level_illegal == &status_word[5:4])
    else $error("level decode");
  a_irq_step: assert property (
    flow_event == ev_irq |=> ##1 status_word[5:4] inside {2'h1, 2'h2})
    else $error("irq level");
  a_call_push: assert property (
    flow_event == ev_call |=> status_push[5:0] == 6'h0)
    else $error("call push");
  a_carry_set: assert property (
    carry_op == op_carry_set && flow_event == ev_none
    |=> ##1 carry_flag && mem_bit_out) else $error("carry set");
  c_irq: cover property (flow_event == ev_irq);
  c_pop: cover property (pop_bank_select);
  c_refuse: cover property (sel_mem_bank && !ok_arg);
endmodule // status_word_asserts
bind status_word_and_bank_select status_word_asserts u_chk (.*);

/* File: bench/stack_model.sv */
// sequencer stack side: keeps one saved status or bank byte
`timescale 1ns/1ns
module stack_model
  import status_word_pkg::*;
(
  input  wire logic        ref_clk, push_bank, pop_bank_select,
  input  wire flow_event_e flow_event,
  input  wire logic [7:0]  status_push, bank_select,
  output logic [7:0]       stack_out, saved
);
  flow_event_e ev_q;
  always @(posedge ref_clk) begin
    ev_q <= flow_event;
    if (ev_q == ev_call || ev_q == ev_irq) saved <= status_push;
    else if (push_bank) saved <= bank_select;
  end
  // idle bus shows the inverse so a stale byte never looks valid
  assign stack_out = (pop_bank_select || flow_event inside {ev_ret, ev_return_from_interrupt})
    ? saved : ~saved;
endmodule // stack_model

/* File: bench/status_word_and_bank_select_test.sv */
// self-checking bench for the status word and bank select block
`timescale 1ns/1ns
module status_word_and_bank_select_test;
  import status_word_pkg::*;
  logic ref_clk = 0, reset_n = 0, arith_carry = 0, mem_bit_in = 0;
  logic skip_load = 0, mem_wr = 0, sel_mem_bank = 0, sel_reg_bank = 0;
  logic pop_bank_select = 0, push_bank = 0, carry_flag, carry_skip;
  logic mem_bit_out, irq_any_ok, irq_higher_ok, level_illegal;
  logic [7:0] vector_byte = 8'hc0, stack_in, status_word, status_push;
  logic [7:0] bank_select, saved;
  logic [2:0] skip_in = 3'h0;
  logic [11:0] mem_addr = 12'h0;
  logic [3:0] mem_wdata = 4'h0, bank_arg = 4'h0, data_bank;
  logic [1:0] reg_bank;
  carry_op_e carry_op = op_none;
  flow_event_e flow_event = ev_none;
  int num_errors = 0, tests_run = 0, cycles = 0;
  always #50 ref_clk = ~ref_clk;
  status_word_and_bank_select u_dut (.*);
  stack_model u_stack (.ref_clk, .push_bank, .pop_bank_select, .flow_event,
    .status_push, .bank_select, .stack_out(stack_in), .saved);
  task chk(input string name, input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one request cycle, then one more edge for the registered outputs
  task fire;
    @(posedge ref_clk) #1;
    {skip_load, mem_wr, sel_mem_bank, sel_reg_bank} = 4'h0;
    {pop_bank_select, push_bank} = 2'h0;
    carry_op = op_none;
    flow_event = ev_none;
    @(posedge ref_clk) #1;
  endtask
  task t_banks;
    logic [3:0] good[5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hf};
    foreach (good[i]) begin
      sel_mem_bank = 1; bank_arg = good[i]; fire;
      chk("data_bank", data_bank, good[i]);
    end
    sel_mem_bank = 1; bank_arg = 4'h7; fire;
    chk("refused", bank_select[7:4], 4'hf);
    sel_mem_bank = 1; bank_arg = 4'h2; fire;
    sel_reg_bank = 1; bank_arg = 4'h1; fire;
    push_bank = 1; fire;
    sel_reg_bank = 1; bank_arg = 4'h3; fire;
    chk("reg_bank", reg_bank, 2'h3);
    pop_bank_select = 1; fire;
    chk("popped", bank_select, 8'h21);
  endtask
  task t_carry;
    carry_op_e op[10] = '{op_carry_set, op_carry_clr, op_carry_not, op_bit_and,
      op_bit_or, op_bit_xor, op_bit_load, op_carry_arith, op_bit_store,
      op_carry_skip};
    logic mb[10] = '{0, 0, 0, 0, 1, 1, 0, 1, 0, 0};
    logic ex[10] = '{1, 0, 1, 0, 1, 0, 0, 1, 1, 1};
    foreach (op[i]) begin
      carry_op = op[i]; mem_bit_in = mb[i]; arith_carry = mb[i]; fire;
      chk("carry", carry_flag, ex[i]);
    end
    chk("mem_bit_out", mem_bit_out, 1'b1);
    // skip pulse stands only for the cycle after the skip op is taken
    carry_op = op_carry_skip;
    @(posedge ref_clk) #1;
    carry_op = op_none;
    chk("carry_skip", carry_skip, 1'b1);
    @(posedge ref_clk) #1;
    chk("skip drop", carry_skip, 1'b0);
    skip_load = 1; skip_in = 3'h5; fire;
    chk("skips", status_word, 8'hcd);
  endtask
  task t_irq;
    flow_event = ev_call; fire;
    chk("call push", saved, 8'hc0);
    vector_byte = 8'h40; flow_event = ev_irq; fire;
    chk("irq push", saved, 8'hcd);
    chk("irq word", status_word, 8'h5d);
    chk("irq ok", {irq_any_ok, irq_higher_ok}, 2'b01);
    chk("fixed bank", data_bank, 4'h0);
    flow_event = ev_ret; fire;
    chk("ret word", status_word, 8'hdd);
    flow_event = ev_return_from_interrupt; fire;
    chk("return_from_interrupt word", status_word, 8'hcd);
    vector_byte = 8'h80; flow_event = ev_reset_vec; fire;
    chk("reset vec", status_word[7:6], 2'h2);
  endtask
  // no interrupt is raised around these level writes
  task t_level;
    mem_wr = 1; mem_addr = 12'hfb0; mem_wdata = 4'h2; fire;
    chk("level", {irq_any_ok, irq_higher_ok, status_word[5:4]},
        4'h2);
    mem_wr = 1; mem_addr = 12'hfb1; mem_wdata = 4'h0; fire;
    chk("fb1", status_word[5:4], 2'h2);
    mem_wr = 1; mem_addr = 12'hfb0; mem_wdata = 4'h3; fire;
    chk("illegal", {level_illegal, irq_any_ok}, 2'h2);
  endtask
  task tally_and_finish;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 400) begin
      num_errors++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    #1 reset_n = 1;
    repeat (4) @(posedge ref_clk);
    #1 chk("bank reset", bank_select, 8'h00);
    chk("enables", status_word[7:6], 2'h3);
    t_banks;
    t_carry;
    t_irq;
    t_level;
    tally_and_finish;
  end
endmodule // status_word_and_bank_select_test
